/* tdm_channel_bit_timing_tb_top.sv */
// Testbench for the transmit bit timing block
`timescale 1ns/10ps
module tdm_channel_bit_timing_tb_top;
  reg core_clk, rst_n, avs_read, avs_write;
  reg [3:0] avs_address;
  reg [31:0] avs_writedata;
  reg [23:0] pat;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, bus_bit_clock, channel_type_line;
  wire [4:0] channel_addr;
  wire [2:0] type_history;
  wire type_delayed, dv_enable, counter_load_pulse;
  wire [1:0] path_select;
  wire s12_n, s67_n, s78_n;
  wire [2:0] strb_n;
  assign strb_n = {s78_n, s67_n, s12_n};
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int term [8] = '{3, 4, 6, 8, 12, 24, 24, 24};
  tdmbt_timing i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_bit_clock(bus_bit_clock), .channel_type_line(channel_type_line),
    .channel_addr(channel_addr), .channel_slot_strobe_n(),
    .frame_slot_n(), .strobe_one_two_n(s12_n), .strobe_six_seven_n(s67_n),
    .strobe_seven_eight_n(s78_n), .bit_two_time_n(), .bit_eight_time_n(),
    .end_of_count(), .frame_restart(),
    .counter_load_pulse(counter_load_pulse),
    .type_history(type_history), .type_delayed(type_delayed),
    .dv_enable(dv_enable), .path_select(path_select));
  tdmbt_chan_model i_chan (.chan(channel_addr), .pat(pat),
    .bit_clk(bus_bit_clock), .type_line(channel_type_line));
  //////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  task stop_test;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Compare and count
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      num_checks++;
      if (s !== e) begin
        error_cnt++;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // One register cycle, held until waitrequest is seen low at an edge
  task bus(input w, input [3:0] a, input [31:0] wd, output [31:0] rd);
    int n;
    begin
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 100) begin
        error_cnt++;
        stop_test();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Wait for counter load, note the cycle
  task wait_load(output int t);
    int n;
    begin
      n = 0;
      @(negedge core_clk);
      while (counter_load_pulse !== 1'b1 && n < 5000) begin
        @(negedge core_clk);
        n++;
      end
      if (n >= 5000) begin
        error_cnt++;
        stop_test();
      end
      t = cyc;
    end
  endtask
  //////////////////////////////////////////
  // Reset value, unmapped and read-only places
  task t_regs;
    logic [31:0] d;
    begin
      bus(1'b0, 4'h0, 32'h0, d);
      chk("ctrl", 32'hd, d);
      bus(1'b1, 4'hc, 32'h3, d);
      bus(1'b0, 4'hc, 32'h0, d);
      chk("unmapped", 32'h0, d);
      bus(1'b1, 4'h4, 32'hffffffff, d);
      bus(1'b0, 4'h0, 32'h0, d);
      chk("ctrl_kept", 32'hd, d);
    end
  endtask
  // Frame length in every mode
  task t_modes;
    int m, t0, t1;
    logic [31:0] d;
    begin
      for (m = 0; m < 8; m++) begin
        d = m;
        if (m > 4) d[3] = 1'b1;
        bus(1'b1, 4'h0, d, d);
        wait_load(t0);
        wait_load(t0);
        wait_load(t1);
        chk("frame_len", (term[m] * 8 + (m > 4)) * 12, t1 - t0);
        repeat (2) @(negedge core_clk);
        chk("addr_zero", 32'h0, channel_addr);
        @(posedge core_clk);
      end
    end
  endtask
  // Channel type history and data/voice select
  task t_hist(input [23:0] p);
    int k, n, t;
    logic [2:0] he;
    logic dv;
    logic [31:0] d;
    begin
      pat <= p;
      bus(1'b1, 4'h0, 32'h3, d);
      wait_load(t);
      wait_load(t);
      for (k = 1; k < 3; k++) begin
        n = 0;
        while (channel_addr !== k && n < 200) begin
          @(negedge core_clk);
          n++;
        end
        if (n >= 200) begin
          error_cnt++;
          stop_test();
        end
        repeat (48) @(negedge core_clk);
        he = {~p[(k + 5) % 8], ~p[(k + 6) % 8], ~p[(k + 7) % 8]};
        dv = ~(he[0] & ~p[k]);
        chk("history", he, type_history);
        chk("dv_enable", dv, dv_enable);
        chk("path_select", {1'b0, dv}, path_select);
        chk("type_delayed", p[k], type_delayed);
        @(posedge core_clk);
        bus(1'b0, 4'h8, 32'h0, d);
        chk("chan_bits", 32'h1 << k, d);
      end
    end
  endtask
  // Low width of one combined strobe in a chosen channel
  task t_width(input [31:0] c, input int ch, input int sel, input int w);
    int n, lo;
    logic [31:0] d;
    begin
      n = 0;
      lo = 0;
      bus(1'b1, 4'h0, c, d);
      while (channel_addr === ch && n < 3000) begin
        @(negedge core_clk);
        n++;
      end
      while (channel_addr !== ch && n < 3000) begin
        @(negedge core_clk);
        n++;
      end
      while (strb_n[sel] !== 1'b1 && n < 3000) begin
        @(negedge core_clk);
        n++;
      end
      while (strb_n[sel] !== 1'b0 && n < 3000) begin
        @(negedge core_clk);
        n++;
      end
      while (strb_n[sel] === 1'b0 && lo < 40) begin
        @(negedge core_clk);
        lo++;
      end
      if (n >= 3000) begin
        error_cnt++;
        stop_test();
      end
      chk("strobe_width", w, lo);
      @(posedge core_clk);
    end
  endtask
  //////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    pat = 24'h0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_modes();
    t_hist(24'h555555);
    t_hist(24'h000000);
    t_hist(24'hffffff);
    t_width(32'h3, 1, 0, 24);
    t_width(32'h3, 1, 2, 24);
    t_width(32'hd, 5, 0, 12);
    t_width(32'hd, 5, 1, 12);
    t_width(32'hd, 5, 2, 12);
    t_width(32'hd, 0, 0, 24);
    stop_test();
  end
endmodule
bind tdmbt_timing tdmbt_props #(.CHANNELS(CHANNELS)) i_props (
  .core_clk(core_clk), .rst_n(rst_n), .channel_addr(channel_addr),
  .channel_slot_strobe_n(channel_slot_strobe_n),
  .frame_slot_n(frame_slot_n), .end_of_count(end_of_count),
  .frame_restart(frame_restart), .counter_load_pulse(counter_load_pulse),
  .type_history(type_history), .strobe_six_seven_n(strobe_six_seven_n),
  .strobe_seven_eight_n(strobe_seven_eight_n),
  .bit_two_time_n(bit_two_time_n), .bit_eight_time_n(bit_eight_time_n));

/* tdmbt_chan_model.sv */
// Channel modules and bus bit clock source
`timescale 1ns/10ps
module tdmbt_chan_model (
  input wire [4:0] chan,
  input wire [23:0] pat,
  output logic bit_clk,
  output logic type_line
);
  // Free running bit clock, twelve core cycles
  initial begin
    bit_clk = 1'b0;
    #3;
    forever #60 bit_clk = ~bit_clk;
  end
  // High for data module, low for voice
  always @* begin
    if (chan < 5'h18) type_line = pat[chan];
    else type_line = ~pat[23]; // No module in frame slot
  end
endmodule

/* tdmbt_consts.vh */
// Constants for the transmit channel bit timing block
// How it works
// R1: Mode inputs pick terminal channel count
// R2: Full frame mode blocks bit-eight reset start
// R3: Full frame reset held one bit for frame
// R4: Gated channel match reclocked before restart
// R5: Eight-bit counter: 3 bit, 5 channel bits
// R6: Restart loads zeros into whole counter
// R7: Channel count bits go out as address
// R8: Bit strobes reclocked on inverted bit clock
// R9: Full frame selects bit six, bit one
// R10: Seven-eight strobe is six-seven delayed one bit
// R11: First two channels switch selector alternate inputs
// R12: Channel bits decode into 24 low strobes
// R13: Counter MSB enables decoder halves
// R14: Twenty-fifth state gives one-bit frame slot
// R15: Channel module drives type line high for data
// R16: Capture inverted type at bit two
// R17: Seven-eight strobe shifts three-channel history
// R18: Type line copy reclocked at bit two
// R19: History output gated with inverted type
// R20: Enable picks voice or data; frame overrides
// R21: Counter steps once per bit clock
// R22: Short modes restart at last bit eight
`ifndef TDMBT_CONSTS_VH
`define TDMBT_CONSTS_VH
// Register byte offsets
`define TDMBT_OFF_CTRL 4'h0
`define TDMBT_OFF_STATUS 4'h4
`define TDMBT_OFF_CHANNEL 4'h8
// Control fields
`define TDMBT_CTRL_MODE_LSB 0
`define TDMBT_CTRL_FULL_BIT 3
`define TDMBT_CTRL_RST 4'hd
// Terminal channel counts per mode select value
`define TDMBT_TERM_0 5'h03
`define TDMBT_TERM_1 5'h04
`define TDMBT_TERM_2 5'h06
`define TDMBT_TERM_3 5'h08
`define TDMBT_TERM_4 5'h0c
`define TDMBT_TERM_5 5'h18
`define TDMBT_TERM_6 5'h18
`define TDMBT_TERM_7 5'h18
// Channel value of the frame bit slot
`define TDMBT_FRAME_CHAN 5'h18
// Bit slot codes in the low counter bits
`define TDMBT_BIT_ONE 3'h0
`define TDMBT_BIT_TWO 3'h1
`define TDMBT_BIT_SIX 3'h5
`define TDMBT_BIT_SEVEN 3'h6
`define TDMBT_BIT_EIGHT 3'h7
`endif

/* tdmbt_props.sv */
// Port checker for the transmit bit timing block
`timescale 1ns/10ps
module tdmbt_props #(
  parameter CHANNELS = 24
) (
  input wire core_clk,
  input wire rst_n,
  input wire [4:0] channel_addr,
  input wire [CHANNELS-1:0] channel_slot_strobe_n,
  input wire frame_slot_n,
  input wire end_of_count,
  input wire frame_restart,
  input wire counter_load_pulse,
  input wire [2:0] type_history,
  input wire strobe_six_seven_n,
  input wire strobe_seven_eight_n,
  input wire bit_two_time_n,
  input wire bit_eight_time_n
);
  // History one clock ago
  reg [2:0] hist_q;
  always @(posedge core_clk) begin
    hist_q <= type_history;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////
  chk_load_zero: assert property (counter_load_pulse |-> ##[0:2]
    channel_addr == 5'h00) else $error("Counter not cleared");
  chk_load_single: assert property (counter_load_pulse |=>
    !counter_load_pulse) else $error("Load pulse too long");
  chk_load_restart: assert property (counter_load_pulse |->
    ##[0:2] frame_restart) else $error("Load without restart");
  chk_addr_step: assert property (channel_addr != $past(channel_addr)
    |-> channel_addr == $past(channel_addr) + 5'h01
    || channel_addr == 5'h00) else $error("Channel skipped");
  chk_strobe_one: assert property ($onehot0(~channel_slot_strobe_n))
    else $error("Several channel strobes low");
  chk_strobe_match: assert property ($stable(channel_addr)[*8] ##0
    (channel_addr < 5'h18) |-> !channel_slot_strobe_n[channel_addr])
    else $error("Channel strobe missing");
  chk_frame_quiet: assert property (!frame_slot_n |->
    &channel_slot_strobe_n) else $error("Strobe in frame slot");
  chk_frame_len: assert property ($fell(frame_slot_n) |->
    ##[10:14] $rose(frame_slot_n)) else $error("Frame slot length");
  chk_match_addr: assert property ($rose(end_of_count) |->
    channel_addr inside {2, 3, 5, 7, 11, 23})
    else $error("Count match at wrong channel");
  chk_hist_shift: assert property (type_history != hist_q |->
    type_history[2:1] == hist_q[1:0]) else $error("History not shifted");
  chk_b2_width: assert property ($fell(bit_two_time_n) |->
    ##12 $rose(bit_two_time_n)) else $error("Bit two strobe width");
  chk_b8_after_b2: assert property ($fell(bit_two_time_n) |->
    ##72 $fell(bit_eight_time_n)) else $error("Bit eight strobe late");
  chk_s78_delay: assert property ($fell(strobe_six_seven_n) |->
    ##11 $fell(strobe_seven_eight_n))
    else $error("Seven-eight strobe not delayed");
  chk_restart_len: assert property ($rose(frame_restart) |->
    ##12 $fell(frame_restart)) else $error("Restart not one bit");
  // Main scenarios reached
  cover property (!frame_slot_n);
  cover property (counter_load_pulse);
  cover property ($rose(end_of_count));
  cover property ($fell(strobe_seven_eight_n));
endmodule

/* tdmbt_timing.v */
// Transmit bit and channel timing with register slave
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "tdmbt_consts.vh"
module tdmbt_timing #(
  parameter CHANNELS = 24
) (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire bus_bit_clock,
  input wire channel_type_line,
  output wire [4:0] channel_addr,
  output reg [CHANNELS-1:0] channel_slot_strobe_n,
  output reg frame_slot_n,
  output reg strobe_one_two_n,
  output reg strobe_six_seven_n,
  output reg strobe_seven_eight_n,
  output reg bit_two_time_n,
  output reg bit_eight_time_n,
  output reg end_of_count,
  output reg frame_restart,
  output reg counter_load_pulse,
  output reg [2:0] type_history,
  output reg type_delayed,
  output reg dv_enable,
  output reg [1:0] path_select
);

////////////////////////////////////////////////////////////////
// Reset release

// Two-stage release of the async reset
reg rst_meta_reg;
reg rst_sync_n;

// Assert at once, release after two edges
always @(posedge core_clk or negedge rst_n) begin
  if (!rst_n) begin
    rst_meta_reg <= 1'b0;
    rst_sync_n <= 1'b0;
  end else begin
    rst_meta_reg <= 1'b1;
    rst_sync_n <= rst_meta_reg;
  end
end

////////////////////////////////////////////////////////////////
// Pin synchronisers

// Bit clock stages; first stage feeds second only
reg bclk_meta_reg;
reg bclk_sync_reg;
reg bclk_last_reg;
// Type line stages
reg ctype_meta_reg;
reg ctype_sync_reg;

// Sample pins through two flops
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    bclk_meta_reg <= 1'b0;
    bclk_sync_reg <= 1'b0;
    bclk_last_reg <= 1'b0;
    ctype_meta_reg <= 1'b0;
    ctype_sync_reg <= 1'b0;
  end else begin
    bclk_meta_reg <= bus_bit_clock;
    bclk_sync_reg <= bclk_meta_reg;
    bclk_last_reg <= bclk_sync_reg;
    ctype_meta_reg <= channel_type_line;
    ctype_sync_reg <= ctype_meta_reg;
  end
end

// Rising edge of the bit clock
wire rise_tick;
// Rising edge of the inverted phase
wire fall_tick;
assign rise_tick = bclk_sync_reg & ~bclk_last_reg;
assign fall_tick = ~bclk_sync_reg & bclk_last_reg;

////////////////////////////////////////////////////////////////
// Control register

// Mode select and full frame flag
reg [3:0] ctrl_reg;
// Mode select lines
wire [2:0] mode_sel;
// Full frame mode flag
wire full_mode;
assign mode_sel = ctrl_reg[`TDMBT_CTRL_MODE_LSB+2:`TDMBT_CTRL_MODE_LSB];
assign full_mode = ctrl_reg[`TDMBT_CTRL_FULL_BIT];

////////////////////////////////////////////////////////////////
// Bit/channel counter

// Low three bits count bits, top five count channels
reg [7:0] cnt_reg;
reg [7:0] cnt_next;
// Bit slot within channel
wire [2:0] bit_slot;
// Channel number, zero based
wire [4:0] chan;
assign bit_slot = cnt_reg[2:0]; // R5
assign chan = cnt_reg[7:3]; // R5
// Channel address for the coder
assign channel_addr = chan; // R7

// Reclocked gated channel match
reg match_reg;

// Counter next value
always @* begin
  cnt_next = cnt_reg;
  if (rise_tick) begin
    if (match_reg) begin
      // Parallel load of zeros
      cnt_next = 8'h00; // R6
    end else begin
      // One step per bit clock
      cnt_next = cnt_reg + 8'h01; // R21
    end
  end
end

// Counter state
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    cnt_reg <= 8'h00;
  end else begin
    cnt_reg <= cnt_next;
  end
end

////////////////////////////////////////////////////////////////
// Channel counter control and reset

// Terminal count from the eight-way selector
reg [4:0] term_count;

// Eight-way selector on the mode lines
always @* begin
  case (mode_sel) // R1
    3'h0: begin
      term_count = `TDMBT_TERM_0;
    end
    3'h1: begin
      term_count = `TDMBT_TERM_1;
    end
    3'h2: begin
      term_count = `TDMBT_TERM_2;
    end
    3'h3: begin
      term_count = `TDMBT_TERM_3;
    end
    3'h4: begin
      term_count = `TDMBT_TERM_4;
    end
    3'h5: begin
      term_count = `TDMBT_TERM_5;
    end
    3'h6: begin
      term_count = `TDMBT_TERM_6;
    end
    default: begin
      term_count = `TDMBT_TERM_7;
    end
  endcase
end

// Counter sits in the last selected channel
wire last_chan;
assign last_chan = (chan == term_count - 5'h01); // R1

// Bit eight path, blocked in full frame mode
wire short_gate;
assign short_gate = ~full_mode & last_chan &
  (bit_slot == `TDMBT_BIT_EIGHT); // R2 R22
// Full frame path: frame slot state reached
wire full_gate;
assign full_gate = full_mode & (chan == `TDMBT_FRAME_CHAN); // R3 R14

// Reclock the gated match on the inverted phase
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    match_reg <= 1'b0;
    end_of_count <= 1'b0;
  end else if (fall_tick) begin
    match_reg <= short_gate | full_gate; // R4
    end_of_count <= last_chan; // R1
  end
end

// Restart level for one bit period, load pulse one cycle
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    frame_restart <= 1'b0;
    counter_load_pulse <= 1'b0;
  end else begin
    counter_load_pulse <= rise_tick & match_reg; // R6
    if (rise_tick) begin
      frame_restart <= match_reg; // R3 R22
    end
  end
end

////////////////////////////////////////////////////////////////
// Bit counter decode and strobe selector

// Active-low one-of-eight bit decode
reg [7:0] bit_dec_n;
// Reclocked bit strobes, active low
reg [7:0] bit_str_n;
// First two channels flags, active low
wire first_flag_n;
wire second_flag_n;
assign first_flag_n = ~(chan == 5'h00);
assign second_flag_n = ~(chan == 5'h01);
// Selector on alternate inputs
wire sel_alt;
assign sel_alt = ~full_mode |
  (full_mode & (~first_flag_n | ~second_flag_n)); // R9 R11

// Decode the three bit counter bits
always @* begin
  bit_dec_n = 8'hff;
  bit_dec_n[bit_slot] = 1'b0;
end

// Reclock strobes on the inverted bit clock
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    bit_str_n <= 8'hff;
  end else if (fall_tick) begin
    bit_str_n <= bit_dec_n; // R8
  end
end

// Combined strobes chosen by the selector
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    strobe_one_two_n <= 1'b1;
    strobe_six_seven_n <= 1'b1;
    strobe_seven_eight_n <= 1'b1;
    bit_two_time_n <= 1'b1;
    bit_eight_time_n <= 1'b1;
  end else begin
    bit_two_time_n <= bit_str_n[1]; // R8
    bit_eight_time_n <= bit_str_n[7]; // R8
    if (sel_alt) begin
      // Alternate inputs: two-slot strobes
      strobe_one_two_n <= bit_str_n[0] & bit_str_n[1]; // R11
      strobe_six_seven_n <= bit_str_n[5] & bit_str_n[6]; // R11
    end else begin
      // First inputs: single slots
      strobe_one_two_n <= bit_str_n[0]; // R9
      strobe_six_seven_n <= bit_str_n[5]; // R9
    end
    if (fall_tick) begin
      strobe_seven_eight_n <= strobe_six_seven_n; // R10
    end
  end
end

////////////////////////////////////////////////////////////////
// Channel counter decode

// Half enables from the counter MSB
wire low_half_en;
wire high_half_en;
assign high_half_en = chan[4]; // R13
assign low_half_en = ~chan[4]; // R13
// Raw active-low decode
wire [CHANNELS-1:0] chan_dec_n;

genvar gi;
generate
  for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
    // Each output matches the low four bits in its half
    if (gi < 16) begin : g_low
      assign chan_dec_n[gi] = ~(low_half_en &
        (chan[3:0] == gi[3:0])); // R12 R13
    end else begin : g_high
      assign chan_dec_n[gi] = ~(high_half_en &
        (chan[3:0] == gi[3:0])); // R12 R13
    end
  end
endgenerate

// Latch the decode at each bit clock edge
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    channel_slot_strobe_n <= {CHANNELS{1'b1}};
    frame_slot_n <= 1'b1;
  end else if (rise_tick | fall_tick) begin
    channel_slot_strobe_n <= chan_dec_n; // R12
    // Twenty-fifth output marks the frame bit, full frame only
    frame_slot_n <= ~(full_mode & high_half_en &
      (chan[3:0] == 4'h8)); // R14
  end
end

////////////////////////////////////////////////////////////////
// Data/voice enable

// Inverted type captured at bit two
reg held_type_reg;
// Edge detect on the seven-eight strobe
reg s78_last_reg;
wire s78_start;
assign s78_start = ~strobe_seven_eight_n & s78_last_reg;
// Bit two capture moment
wire bit_two_evt;
assign bit_two_evt = fall_tick & ~bit_dec_n[1];

// Capture, history shift and copy
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    held_type_reg <= 1'b0;
    s78_last_reg <= 1'b1;
    type_history <= 3'h0;
    type_delayed <= 1'b0;
  end else begin
    s78_last_reg <= strobe_seven_eight_n;
    if (bit_two_evt) begin
      held_type_reg <= ~ctype_sync_reg; // R16
      type_delayed <= ctype_sync_reg; // R18
    end
    if (s78_start) begin
      type_history <= {type_history[1:0], held_type_reg}; // R17
    end
  end
end

// Enable: high picks data path, frame bit wins
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    dv_enable <= 1'b0;
    path_select <= 2'h0;
  end else begin
    dv_enable <= ~(type_history[0] & ~ctype_sync_reg); // R19
    if (!frame_slot_n) begin
      path_select <= 2'h2; // R20
    end else begin
      path_select <= {1'b0, dv_enable}; // R20
    end
  end
end

////////////////////////////////////////////////////////////////
// Avalon-MM slave

// Answer one cycle after the request
reg ack_reg;
wire req;
assign req = avs_read | avs_write;
assign avs_waitrequest = req & ~ack_reg;

// Read mux of local state
reg [31:0] rd_mux;
always @* begin
  case (avs_address)
    `TDMBT_OFF_CTRL: begin
      rd_mux = {28'h0000000, ctrl_reg};
    end
    `TDMBT_OFF_STATUS: begin
      rd_mux = {19'h00000, frame_restart, dv_enable,
        type_history, cnt_reg};
    end
    `TDMBT_OFF_CHANNEL: begin
      rd_mux = {8'h00, ~channel_slot_strobe_n};
    end
    default: begin
      rd_mux = 32'h00000000;
    end
  endcase
end

// Handshake, read data and control writes
always @(posedge core_clk or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    ack_reg <= 1'b0;
    avs_readdata <= 32'h00000000;
    ctrl_reg <= `TDMBT_CTRL_RST;
  end else begin
    ack_reg <= req & ~ack_reg;
    if (avs_read & ~ack_reg) begin
      avs_readdata <= rd_mux;
    end
    if (avs_write & ack_reg &
        (avs_address == `TDMBT_OFF_CTRL)) begin
      ctrl_reg <= avs_writedata[3:0]; // R1
    end
  end
end

endmodule
